// >>> tpt_params.svh
`ifndef TPT_PARAMS_SVH
`define TPT_PARAMS_SVH
// special function register addresses
`define TPT_ADDR_CLKCTL 8'h8e
`define TPT_ADDR_T2CTL 8'hc8
`define TPT_ADDR_RCAPL 8'hca
`define TPT_ADDR_RCAPH 8'hcb
`define TPT_ADDR_CNTL 8'hcc
`define TPT_ADDR_CNTH 8'hcd
// reset values
`define TPT_CLKCTL_RST 8'h01
`define TPT_T2CTL_RST 8'h00
`define TPT_CNT_RST 16'h0000
// timer_clock_control fields
`define TPT_BIT_T2FAST 5
`define TPT_BIT_T1FAST 4
`define TPT_BIT_T0FAST 3
`define TPT_CLKCTL_MASK 8'h3f
`define TPT_MOVE_BASE 4'h2
// timer2_control fields
`define TPT_BIT_OVF 7
`define TPT_BIT_EXF 6
`define TPT_BIT_RXSRC 5
`define TPT_BIT_TXSRC 4
`define TPT_BIT_TRIGEN 3
`define TPT_BIT_RUN 2
`define TPT_BIT_CTSEL 1
`define TPT_BIT_CPRL 0
// prescaler: last count value and tick match values
`define TPT_PRE_LAST 4'hb
`define TPT_PRE_SLOW_TICK 4'hb
`define TPT_PRE_FAST_TICK 2'h3
`define TPT_CNT_MAX 16'hffff
`endif

// >>> tpt_pkg.sv
package tpt_pkg;
  typedef enum logic [3:0] {
    TPT_OFF = 4'h1,
    TPT_CAPTURE = 4'h2,
    TPT_RELOAD = 4'h4,
    TPT_BAUD = 4'h8
  } tpt_mode_e;
  typedef logic [7:0] tpt_byte_t;
endpackage : tpt_pkg

// >>> tpt_fall_sync.sv
`timescale 1ns/10ps
module tpt_fall_sync (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic pinIn,
  output logic fallPulse
);
  logic meta_r;
  logic sync_r;
  logic prev_r;
  // meta_r feeds only sync_r; edge check looks at later stages
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      prev_r <= 1'b1;
      fallPulse <= 1'b0;
    end else begin
      meta_r <= pinIn;
      sync_r <= meta_r;
      prev_r <= sync_r;
      fallPulse <= prev_r & ~sync_r;
    end
  end
endmodule : tpt_fall_sync

// >>> tpt_timer2.sv
//
// Functional notes
// - clock-select bits 5/4/3: set gives four-clock ticks, clear twelve
// - all three clock-select bits read zero after reset
// - clock-select bits do not affect external pin counting
// - baud mode internal count ticks every two clocks, ignores select
// - stretch field sets move length two plus field, resets to one
// - overflow flag set on 0xffff overflow only when both sources zero
// - software writing one to either flag sets it, raising interrupt
// - external flag set on any enabled trigger edge, baud mode included
// - receive source bit picks timer2 or timer1 overflow, modes 1/3
// - transmit source bit picks timer2 or timer1 overflow, modes 1/3
// - trigger edge captures or reloads only when enabled and not in baud mode
// - timer2 counts only while run bit is one
// - count select: zero prescaled clock, one falling pin edges
// - either source bit forces baud mode; else select capture/reload
// - capture mode trigger edge copies count bytes, count continues
// - reload mode overflow sets flag and reloads count
// - reload mode trigger edge forces a reload
// - baud overflow pulses shift clock, no flag, still reloads
// - in baud mode only the external flag raises interrupt
// - count and capture value split into low and high bytes
`timescale 1ns/10ps
`include "tpt_params.svh"
module tpt_timer2 (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrEn,
  input wire tpt_pkg::tpt_byte_t sfrWrData,
  input wire logic sfrRdEn,
  output tpt_pkg::tpt_byte_t sfrRdData,
  input wire logic extCountPin,
  input wire logic triggerInput,
  input wire logic timer1Overflow,
  input wire logic [1:0] serialMode,
  output logic timer2Irq,
  output logic rxShiftClk,
  output logic txShiftClk,
  output logic timer0Tick,
  output logic timer1Tick,
  output logic [2:0] externalMoveStretch,
  output logic [3:0] externalMoveCycles
);
  import tpt_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic [7:0] clkCtl_r;
  logic [7:0] t2Ctl_r;
  logic [15:0] count_r;
  logic [15:0] countNxt;
  logic [15:0] rcap_r;
  logic [15:0] rcapNxt;
  logic [3:0] pre_r;
  logic tick2;
  logic tick4;
  logic tick12;
  logic extFall;
  logic trigFall;
  logic incEn;
  logic ovf;
  logic baud;
  logic trigEvt;
  logic ovfSet;
  logic exfSet;
  logic ovfNxt;
  logic exfNxt;
  logic wrClk;
  logic wrCtl;
  logic wrRl;
  logic wrRh;
  logic wrCl;
  logic wrCh;
  tpt_mode_e mode;

  assign wrClk = sfrWrEn && sfrAddr == `TPT_ADDR_CLKCTL;
  assign wrCtl = sfrWrEn && sfrAddr == `TPT_ADDR_T2CTL;
  assign wrRl = sfrWrEn && sfrAddr == `TPT_ADDR_RCAPL;
  assign wrRh = sfrWrEn && sfrAddr == `TPT_ADDR_RCAPH;
  assign wrCl = sfrWrEn && sfrAddr == `TPT_ADDR_CNTL;
  assign wrCh = sfrWrEn && sfrAddr == `TPT_ADDR_CNTH;

  ////////////////////////////////////////////////////////////////////////
  // pin edge detection
  tpt_fall_sync u_countPin (
    .clk(clk),
    .sys_rst(sys_rst),
    .pinIn(extCountPin),
    .fallPulse(extFall)
  );
  tpt_fall_sync u_trigger (
    .clk(clk),
    .sys_rst(sys_rst),
    .pinIn(triggerInput),
    .fallPulse(trigFall)
  );

  ////////////////////////////////////////////////////////////////////////
  // shared prescaler; one counter gives /2, /4 and /12 so ticks stay aligned
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pre_r <= 4'h0;
    end else if (pre_r == `TPT_PRE_LAST) begin
      pre_r <= 4'h0;
    end else begin
      pre_r <= pre_r + 4'h1;
    end
  end
  assign tick2 = pre_r[0];
  assign tick4 = pre_r[1:0] == `TPT_PRE_FAST_TICK;
  assign tick12 = pre_r == `TPT_PRE_SLOW_TICK;

  // timer0/1 ticks leave for their counters; selects are independent
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      timer0Tick <= 1'b0;
      timer1Tick <= 1'b0;
    end else begin
      timer0Tick <= clkCtl_r[`TPT_BIT_T0FAST] ? tick4 : tick12;
      timer1Tick <= clkCtl_r[`TPT_BIT_T1FAST] ? tick4 : tick12;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // clock control register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      clkCtl_r <= `TPT_CLKCTL_RST;
    end else if (wrClk) begin
      clkCtl_r <= sfrWrData & `TPT_CLKCTL_MASK;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      externalMoveStretch <= 3'h1;
      externalMoveCycles <= 4'h3;
    end else begin
      externalMoveStretch <= clkCtl_r[2:0];
      externalMoveCycles <= `TPT_MOVE_BASE + {1'b0, clkCtl_r[2:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mode decode and count enable
  assign baud = t2Ctl_r[`TPT_BIT_RXSRC] | t2Ctl_r[`TPT_BIT_TXSRC];

  always_comb begin
    if (!t2Ctl_r[`TPT_BIT_RUN]) begin
      mode = TPT_OFF;
    end else if (baud) begin
      mode = TPT_BAUD;
    end else if (t2Ctl_r[`TPT_BIT_CPRL]) begin
      mode = TPT_CAPTURE;
    end else begin
      mode = TPT_RELOAD;
    end
  end

  // external count source skips the prescaler entirely
  always_comb begin
    case (mode)
      TPT_OFF: incEn = 1'b0;
      TPT_BAUD: begin
        // external baud base relies on software choosing the pin
        if (t2Ctl_r[`TPT_BIT_CTSEL]) begin
          incEn = extFall;
        end else begin
          incEn = tick2;
        end
      end
      TPT_CAPTURE, TPT_RELOAD: begin
        if (t2Ctl_r[`TPT_BIT_CTSEL]) begin
          incEn = extFall;
        end else begin
          incEn = clkCtl_r[`TPT_BIT_T2FAST] ? tick4 : tick12;
        end
      end
      default: incEn = 1'b0;
    endcase
  end

  assign ovf = incEn && count_r == `TPT_CNT_MAX;
  // trigger edge ignored when disabled or generating baud rates
  assign trigEvt = trigFall && t2Ctl_r[`TPT_BIT_TRIGEN] && !baud;

  ////////////////////////////////////////////////////////////////////////
  // count and capture/reload bytes; a software byte write wins
  always_comb begin
    countNxt = count_r;
    if (incEn) begin
      countNxt = count_r + 16'h0001;
    end
    if (ovf && mode != TPT_CAPTURE) begin
      countNxt = rcap_r;
    end
    if (trigEvt && !t2Ctl_r[`TPT_BIT_CPRL]) begin
      countNxt = rcap_r;
    end
    if (wrCl) begin
      countNxt[7:0] = sfrWrData;
    end
    if (wrCh) begin
      countNxt[15:8] = sfrWrData;
    end
  end

  always_comb begin
    rcapNxt = rcap_r;
    if (trigEvt && t2Ctl_r[`TPT_BIT_CPRL]) begin
      rcapNxt = count_r;
    end
    if (wrRl) begin
      rcapNxt[7:0] = sfrWrData;
    end
    if (wrRh) begin
      rcapNxt[15:8] = sfrWrData;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_r <= `TPT_CNT_RST;
      rcap_r <= `TPT_CNT_RST;
    end else begin
      count_r <= countNxt;
      rcap_r <= rcapNxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control register; hardware set beats a same-cycle software clear
  assign ovfSet = ovf && !baud;
  assign exfSet = trigFall && t2Ctl_r[`TPT_BIT_TRIGEN];
  assign ovfNxt = ovfSet | (wrCtl ? sfrWrData[`TPT_BIT_OVF]
                                  : t2Ctl_r[`TPT_BIT_OVF]);
  assign exfNxt = exfSet | (wrCtl ? sfrWrData[`TPT_BIT_EXF]
                                  : t2Ctl_r[`TPT_BIT_EXF]);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      t2Ctl_r <= `TPT_T2CTL_RST;
    end else begin
      t2Ctl_r[`TPT_BIT_OVF] <= ovfNxt;
      t2Ctl_r[`TPT_BIT_EXF] <= exfNxt;
      if (wrCtl) begin
        t2Ctl_r[5:0] <= sfrWrData[5:0];
      end
    end
  end

  // interrupt request follows either flag
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      timer2Irq <= 1'b0;
    end else begin
      timer2Irq <= ovfNxt | exfNxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // serial shift clocks, only meaningful in serial modes 1 and 3
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rxShiftClk <= 1'b0;
      txShiftClk <= 1'b0;
    end else begin
      rxShiftClk <= serialMode[0] && (t2Ctl_r[`TPT_BIT_RXSRC] ?
                    (ovf && baud) : timer1Overflow);
      txShiftClk <= serialMode[0] && (t2Ctl_r[`TPT_BIT_TXSRC] ?
                    (ovf && baud) : timer1Overflow);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register read port; unmapped addresses read zero
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sfrRdData <= 8'h00;
    end else if (sfrRdEn) begin
      case (sfrAddr)
        `TPT_ADDR_CLKCTL: sfrRdData <= clkCtl_r;
        `TPT_ADDR_T2CTL: sfrRdData <= t2Ctl_r;
        `TPT_ADDR_RCAPL: sfrRdData <= rcap_r[7:0];
        `TPT_ADDR_RCAPH: sfrRdData <= rcap_r[15:8];
        `TPT_ADDR_CNTL: sfrRdData <= count_r[7:0];
        `TPT_ADDR_CNTH: sfrRdData <= count_r[15:8];
        default: sfrRdData <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_slow_rate: assert property (
    mode != TPT_BAUD && !t2Ctl_r[`TPT_BIT_CTSEL] &&
    !clkCtl_r[`TPT_BIT_T2FAST] && incEn |-> pre_r == 4'hb)
    else $error("slow timer2 tick off the twelve-clock grid");

  chk_fast_rate: assert property (
    mode != TPT_BAUD && !t2Ctl_r[`TPT_BIT_CTSEL] &&
    clkCtl_r[`TPT_BIT_T2FAST] && incEn |-> pre_r[1:0] == 2'h3)
    else $error("fast timer2 tick off the four-clock grid");

  chk_reset_clksel: assert property (
    disable iff (1'b0) $past(sys_rst) |-> clkCtl_r[5:3] == 3'h0)
    else $error("clock selects not zero after reset");

  chk_ext_source: assert property (
    t2Ctl_r[`TPT_BIT_CTSEL] && incEn |-> extFall)
    else $error("external count advanced without pin edge");

  chk_baud_rate: assert property (
    mode == TPT_BAUD && !t2Ctl_r[`TPT_BIT_CTSEL] |-> incEn == pre_r[0])
    else $error("baud mode not counting every two clocks");

  chk_ovf_flag: assert property (
    ovf && !baud |=> t2Ctl_r[`TPT_BIT_OVF] && timer2Irq)
    else $error("overflow flag or interrupt missing");

  chk_baud_noflag: assert property (
    ovf && baud && !t2Ctl_r[`TPT_BIT_OVF] && !wrCtl && !wrCl && !wrCh
    |=> !t2Ctl_r[`TPT_BIT_OVF] && count_r == $past(rcap_r))
    else $error("baud overflow set flag or missed reload");

  chk_run_off: assert property (
    !t2Ctl_r[`TPT_BIT_RUN] && !wrCl && !wrCh && !trigEvt
    |=> $stable(count_r))
    else $error("count moved while stopped");

  chk_capture: assert property (
    trigEvt && t2Ctl_r[`TPT_BIT_CPRL] && !wrRl && !wrRh
    |=> rcap_r == $past(count_r))
    else $error("capture did not copy the count");

  chk_reload_ovf: assert property (
    ovf && mode == TPT_RELOAD && !wrCl && !wrCh
    |=> count_r == $past(rcap_r))
    else $error("reload mode overflow did not reload");

  chk_trig_off: assert property (
    !t2Ctl_r[`TPT_BIT_TRIGEN] && !wrCtl |=> $stable(t2Ctl_r[`TPT_BIT_EXF]))
    else $error("external flag moved with trigger disabled");

  cov_capture: cover property (trigEvt && mode == TPT_CAPTURE);
  cov_reload: cover property (ovf && mode == TPT_RELOAD);
  cov_baud: cover property (ovf && mode == TPT_BAUD ##1 txShiftClk);
endmodule : tpt_timer2

// >>> tpt_partner.sv
`timescale 1ns/10ps
module tpt_partner #(
  parameter int T1_PERIOD = 20
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic modeOneThree,
  input wire logic rxShiftClk,
  input wire logic txShiftClk,
  output logic [1:0] serialMode,
  output logic timer1Overflow,
  output logic [15:0] rxCount,
  output logic [15:0] txCount
);
  logic [7:0] t1Cnt_r;
  //////////////////////////////////////////////////////////////////////////
  // modes 1/3 take timer clocks, mode 2 never does
  assign serialMode = modeOneThree ? 2'h1 : 2'h2;
  //////////////////////////////////////////////////////////////////////////
  // stand-in for timer1: fixed period keeps its overflow easy to tell apart
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      t1Cnt_r <= 8'h00;
      timer1Overflow <= 1'b0;
    end else begin
      t1Cnt_r <= (t1Cnt_r == 8'(T1_PERIOD - 1)) ? 8'h00 : t1Cnt_r + 8'h01;
      timer1Overflow <= (t1Cnt_r == 8'(T1_PERIOD - 1));
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // serial side only counts the shift clocks it is given
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rxCount <= 16'h0000;
      txCount <= 16'h0000;
    end else begin
      rxCount <= rxCount + 16'(rxShiftClk);
      txCount <= txCount + 16'(txShiftClk);
    end
  end
endmodule : tpt_partner

// >>> tpt_timer2_tb_top.sv
`timescale 1ns/10ps
`include "tpt_params.svh"
module tpt_timer2_tb_top;
  import tpt_pkg::*;
  logic clk, sys_rst, sfrWrEn, sfrRdEn, extCountPin, triggerInput;
  logic [7:0] sfrAddr;
  tpt_byte_t sfrWrData, sfrRdData;
  logic timer1Overflow, timer2Irq, rxShiftClk, txShiftClk;
  logic timer0Tick, timer1Tick, modeOneThree;
  logic [1:0] serialMode;
  logic [2:0] externalMoveStretch;
  logic [3:0] externalMoveCycles, pulses;
  logic [15:0] rxCount, txCount, snap, rxSnap;
  int mismatches, check_count;
  assign pulses = {rxShiftClk, txShiftClk, timer1Tick, timer0Tick};
  tpt_timer2 dut (.clk(clk), .sys_rst(sys_rst), .sfrAddr(sfrAddr),
    .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn),
    .sfrRdData(sfrRdData), .extCountPin(extCountPin),
    .triggerInput(triggerInput), .timer1Overflow(timer1Overflow),
    .serialMode(serialMode), .timer2Irq(timer2Irq),
    .rxShiftClk(rxShiftClk), .txShiftClk(txShiftClk),
    .timer0Tick(timer0Tick), .timer1Tick(timer1Tick),
    .externalMoveStretch(externalMoveStretch),
    .externalMoveCycles(externalMoveCycles));
  tpt_partner partner (.clk(clk), .sys_rst(sys_rst),
    .modeOneThree(modeOneThree), .rxShiftClk(rxShiftClk),
    .txShiftClk(txShiftClk), .serialMode(serialMode),
    .timer1Overflow(timer1Overflow), .rxCount(rxCount), .txCount(txCount));
  always #5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfrAddr = a;
    sfrWrData = d;
    sfrWrEn = 1'b1;
    @(negedge clk);
    sfrWrEn = 1'b0;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    sfrAddr = a;
    sfrRdEn = 1'b1;
    @(negedge clk);
    sfrRdEn = 1'b0;
    chk(16'(sfrRdData), 16'(exp));
  endtask : rdc
  // sync on one pulse, then check the spacing of the second gap after it
  task automatic gap(input int w, input int exp);
    int n;
    for (int k = 0; k < 3; k++) begin
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (pulses[w] !== 1'b1 && n < 300);
    end
    chk(16'(n), 16'(exp));
  endtask : gap
  // pins held four clocks per level, well above the sync depth
  task automatic fall(input bit trig);
    @(negedge clk);
    if (trig) triggerInput = 1'b0;
    else extCountPin = 1'b0;
    repeat (4) @(negedge clk);
    if (trig) triggerInput = 1'b1;
    else extCountPin = 1'b1;
    repeat (4) @(negedge clk);
  endtask : fall
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rdc(`TPT_ADDR_CLKCTL, 8'h01);
    rdc(`TPT_ADDR_T2CTL, 8'h00);
    rdc(8'h90, 8'h00);
    chk(16'(externalMoveCycles), 16'h3);
  endtask : t_reset
  task automatic t_clkctl;
    wr(`TPT_ADDR_CLKCTL, 8'hff);
    rdc(`TPT_ADDR_CLKCTL, 8'h3f);
    chk(16'(externalMoveCycles), 16'h9);
    chk(16'(externalMoveStretch), 16'h7);
    gap(0, 4);
    wr(`TPT_ADDR_CLKCTL, 8'h08);
    gap(0, 4);
    gap(1, 12);
    wr(`TPT_ADDR_CLKCTL, 8'h10);
    gap(0, 12);
    gap(1, 4);
  endtask : t_clkctl
  task automatic t_overflow;
    int n;
    wr(`TPT_ADDR_RCAPL, 8'h34);
    wr(`TPT_ADDR_RCAPH, 8'h12);
    wr(`TPT_ADDR_CNTL, 8'hfe);
    wr(`TPT_ADDR_CNTH, 8'hff);
    wr(`TPT_ADDR_CLKCTL, 8'h21);
    wr(`TPT_ADDR_T2CTL, 8'h04);
    n = 0;
    while (timer2Irq !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk(16'(timer2Irq), 16'h1);
    wr(`TPT_ADDR_T2CTL, 8'h80);
    rdc(`TPT_ADDR_CNTH, 8'h12);
    rdc(`TPT_ADDR_CNTL, 8'h34);
    repeat (60) @(negedge clk);
    rdc(`TPT_ADDR_CNTL, 8'h34);
    wr(`TPT_ADDR_T2CTL, 8'h00);
    @(negedge clk);
    chk(16'(timer2Irq), 16'h0);
    wr(`TPT_ADDR_T2CTL, 8'h40);
    @(negedge clk);
    chk(16'(timer2Irq), 16'h1);
    wr(`TPT_ADDR_T2CTL, 8'h00);
  endtask : t_overflow
  task automatic t_trigger;
    wr(`TPT_ADDR_T2CTL, 8'h09);
    wr(`TPT_ADDR_CNTL, 8'hcd);
    wr(`TPT_ADDR_CNTH, 8'hab);
    fall(1'b1);
    rdc(`TPT_ADDR_RCAPL, 8'hcd);
    rdc(`TPT_ADDR_RCAPH, 8'hab);
    rdc(`TPT_ADDR_T2CTL, 8'h49);
    wr(`TPT_ADDR_T2CTL, 8'h08);
    wr(`TPT_ADDR_RCAPL, 8'h78);
    wr(`TPT_ADDR_RCAPH, 8'h56);
    fall(1'b1);
    rdc(`TPT_ADDR_CNTL, 8'h78);
    rdc(`TPT_ADDR_CNTH, 8'h56);
    rdc(`TPT_ADDR_T2CTL, 8'h48);
    wr(`TPT_ADDR_T2CTL, 8'h01);
    wr(`TPT_ADDR_RCAPL, 8'h00);
    fall(1'b1);
    rdc(`TPT_ADDR_RCAPL, 8'h00);
    rdc(`TPT_ADDR_T2CTL, 8'h01);
  endtask : t_trigger
  task automatic t_baud;
    modeOneThree = 1'b1;
    wr(`TPT_ADDR_RCAPL, 8'hf0);
    wr(`TPT_ADDR_RCAPH, 8'hff);
    wr(`TPT_ADDR_CNTH, 8'hff);
    wr(`TPT_ADDR_CLKCTL, 8'h01);
    wr(`TPT_ADDR_T2CTL, 8'h24);
    gap(3, 32);
    gap(2, 20);
    wr(`TPT_ADDR_T2CTL, 8'h35);
    gap(2, 32);
    rdc(`TPT_ADDR_T2CTL, 8'h35);
    wr(`TPT_ADDR_T2CTL, 8'h3c);
    fall(1'b1);
    rdc(`TPT_ADDR_T2CTL, 8'h7c);
    chk(16'(timer2Irq), 16'h1);
    @(negedge clk);
    modeOneThree = 1'b0;
    repeat (2) @(negedge clk);
    snap = txCount;
    rxSnap = rxCount;
    repeat (100) @(negedge clk);
    chk(txCount, snap);
    chk(rxCount, rxSnap);
    wr(`TPT_ADDR_T2CTL, 8'h00);
  endtask : t_baud
  task automatic t_counter;
    wr(`TPT_ADDR_CNTL, 8'h00);
    wr(`TPT_ADDR_CNTH, 8'h00);
    wr(`TPT_ADDR_CLKCTL, 8'h21);
    wr(`TPT_ADDR_T2CTL, 8'h06);
    repeat (5) fall(1'b0);
    wr(`TPT_ADDR_T2CTL, 8'h02);
    rdc(`TPT_ADDR_CNTL, 8'h05);
    rdc(`TPT_ADDR_CNTH, 8'h00);
  endtask : t_counter
  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  initial begin
    #200000;
    mismatches++;
    report_and_stop();
  end
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    sfrAddr = 8'h00;
    sfrWrEn = 1'b0;
    sfrWrData = 8'h00;
    sfrRdEn = 1'b0;
    extCountPin = 1'b1;
    triggerInput = 1'b1;
    modeOneThree = 1'b0;
    mismatches = 0;
    check_count = 0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    t_reset();
    t_clkctl();
    t_overflow();
    t_trigger();
    t_baud();
    t_counter();
    report_and_stop();
  end
endmodule : tpt_timer2_tb_top
